// file: inc/bus_io_params.svh
// Purpose: offsets, widths and reset values for the bus-shared ports
// Assumes: included by the package user and the port block
// Notes:   definitions only
`ifndef BUS_IO_PARAMS_SVH
`define BUS_IO_PARAMS_SVH
`define OFS_LOW_DIR      8'h10
`define OFS_LOW_DATA     8'h11
`define OFS_HIGH_DIR     8'h12
`define OFS_HIGH_DATA    8'h13
`define OFS_STROBE_DIR   8'h14
`define OFS_STROBE_DATA  8'h15
`define PORT_BANK        4'h1
`define DIR_RESET8       8'hff
`define DIR_RESET4       4'hf
`define LATCH_CLEAR8     8'h00
`define LATCH_CLEAR4     4'h0
`define ZERO_HI4         4'h0
`define BIT_ALE          0
`define BIT_OE           1
`define BIT_WR           2
`define BIT_CAP          3
`endif

// file: inc/bus_io_pkg.sv
// Purpose: types shared by the bus-shared port block
// Assumes: nothing
// Notes:   memory modes as selected by configuration
package bus_io_pkg;
    typedef enum logic [1:0] {
        mode_microcontroller = 2'h0,
        mode_protected_mc    = 2'h1,
        mode_extended_mc     = 2'h2,
        mode_microprocessor  = 2'h3
    } mem_mode_t;
    // bus engine request toward the pins
    typedef struct packed {
        logic [15:0] ad_out;
        logic        ad_drive;
        logic        ale;
        logic        oe_n;
        logic        wr_n;
    } sysbus_req_t;
    // per-pin drive bundle for one 8-bit port
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe_n;
    } pin8_t;
endpackage

// file: core/bus_shared_io_ports.sv
// Purpose: two 8-bit ports and a 4-bit port shared with the muxed system bus
// Assumes: register access on the core clock, bank number held outside
// Notes:   pin output enables are active low; inputs pass 4 flip-flops
//
// Summary of operation
// R1: direction one makes pin input; zero drives the latch value out.
// R2: port read returns pin levels; write loads only the output latch.
// R3: first 8-bit port carries bus bits 7..0 in bus modes.
// R4: second 8-bit port carries bus bits 15..8 in bus modes.
// R5: 4-bit port supplies address latch, output enable and write strobes.
// R6: output enable and write strobes are active low.
// R7: 8-bit ports join the bus in either external-bus mode, else I/O.
// R8: only three strobe pins taken; fourth stays I/O or capture input.
// R9: bit0 latch strobe, bit1 output enable, bit2 write, bit3 capture.
// R10: strobe port has four bits and a 4-bit direction register.
// R11: upper strobe port bits read zero and ignore writes.
// R12: all direction registers reset to ones on every reset.
// R13: latches cleared on power-up, kept across clear and watchdog reset.
// R14: software selects bank 1; registers decode only in that bank.
// R15: software clears latch before making pins outputs.
// R16: bus logic overrides latch and direction while pins serve the bus.
`timescale 1ns/1ns
`include "bus_io_params.svh"
module bus_shared_io_ports
    import bus_io_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        por_n,
    input  wire mem_mode_t   mem_mode,
    input  wire logic [3:0]  bank_select,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    input  wire sysbus_req_t bus_req,
    output logic      [15:0] muxed_address_data_bus,
    output logic             fourth_capture_input,
    input  wire logic [7:0]  low_pin_in,
    output logic      [7:0]  low_pin_out,
    output logic      [7:0]  low_pin_oe_n,
    input  wire logic [7:0]  high_pin_in,
    output logic      [7:0]  high_pin_out,
    output logic      [7:0]  high_pin_oe_n,
    input  wire logic [3:0]  strobe_pin_in,
    output logic      [3:0]  strobe_pin_out,
    output logic      [3:0]  strobe_pin_oe_n
);
    logic [7:0] low_dir_r, high_dir_r;
    logic [3:0] strobe_dir_r;
    logic [7:0] low_lat_r, high_lat_r;
    logic [3:0] strobe_lat_r;
    logic [19:0] s1_r, s2_r, s3_r, pins_r;
    logic        bus_mode;
    logic        sel_ok;
    pin8_t       low_nxt, high_nxt;
    logic [3:0]  strobe_out_nxt, strobe_oe_nxt;

    // bank-qualified register hit
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs) && (bank_select == `PORT_BANK);
    endfunction

    assign sel_ok = (bank_select == `PORT_BANK); // R14
    assign bus_mode = (mem_mode == mode_extended_mc)
                   || (mem_mode == mode_microprocessor); // R7

    // direction registers, set on every reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_dir_r    <= `DIR_RESET8; // R12
            high_dir_r   <= `DIR_RESET8;
            strobe_dir_r <= `DIR_RESET4; // R10
        end else if (reg_wr) begin
            if (hit(reg_addr, `OFS_LOW_DIR)) begin
                low_dir_r <= reg_wdata;
            end else if (hit(reg_addr, `OFS_HIGH_DIR)) begin
                high_dir_r <= reg_wdata;
            end else if (hit(reg_addr, `OFS_STROBE_DIR)) begin
                strobe_dir_r <= reg_wdata[3:0]; // R11
            end
        end
    end

    // output latches: cleared only by power-up, kept over other resets
    always_ff @(posedge clk or negedge por_n) begin
        if (!por_n) begin
            low_lat_r    <= `LATCH_CLEAR8; // R13
            high_lat_r   <= `LATCH_CLEAR8;
            strobe_lat_r <= `LATCH_CLEAR4;
        end else if (reg_wr) begin
            if (hit(reg_addr, `OFS_LOW_DATA)) begin
                low_lat_r <= reg_wdata; // R2
            end else if (hit(reg_addr, `OFS_HIGH_DATA)) begin
                high_lat_r <= reg_wdata;
            end else if (hit(reg_addr, `OFS_STROBE_DATA)) begin
                strobe_lat_r <= reg_wdata[3:0]; // R11
            end
        end
    end

    // three-stage pin synchroniser, change accepted when stages 2 and 3 agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r   <= '0;
            s2_r   <= '0;
            s3_r   <= '0;
            pins_r <= '0;
        end else begin
            s1_r <= {strobe_pin_in, high_pin_in, low_pin_in};
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (int i = 0; i < 20; i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    pins_r[i] <= s3_r[i];
                end
            end
        end
    end

    // register read path returns pin levels for data registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd && sel_ok) begin
            if (reg_addr == `OFS_LOW_DIR) begin
                reg_rdata <= low_dir_r;
            end else if (reg_addr == `OFS_LOW_DATA) begin
                reg_rdata <= pins_r[7:0]; // R2
            end else if (reg_addr == `OFS_HIGH_DIR) begin
                reg_rdata <= high_dir_r;
            end else if (reg_addr == `OFS_HIGH_DATA) begin
                reg_rdata <= pins_r[15:8];
            end else if (reg_addr == `OFS_STROBE_DIR) begin
                reg_rdata <= {`ZERO_HI4, strobe_dir_r}; // R11
            end else if (reg_addr == `OFS_STROBE_DATA) begin
                reg_rdata <= {`ZERO_HI4, pins_r[19:16]}; // R11
            end else begin
                reg_rdata <= '0;
            end
        end
    end

    // pin drive selection: bus engine or port latch
    always_comb begin
        low_nxt.out   = low_lat_r; // R1
        low_nxt.oe_n  = low_dir_r;
        high_nxt.out  = high_lat_r;
        high_nxt.oe_n = high_dir_r;
        strobe_out_nxt = strobe_lat_r;
        strobe_oe_nxt  = strobe_dir_r;
        if (bus_mode) begin
            low_nxt.out   = bus_req.ad_out[7:0]; // R3
            low_nxt.oe_n  = {8{~bus_req.ad_drive}}; // R16
            high_nxt.out  = bus_req.ad_out[15:8]; // R4
            high_nxt.oe_n = {8{~bus_req.ad_drive}};
            strobe_out_nxt[`BIT_ALE] = bus_req.ale; // R5 R9
            strobe_out_nxt[`BIT_OE]  = bus_req.oe_n; // R6
            strobe_out_nxt[`BIT_WR]  = bus_req.wr_n; // R6
            strobe_oe_nxt[2:0] = 3'h0; // R8 R16
        end
    end

    // registered pin outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_pin_out     <= '0;
            low_pin_oe_n    <= `DIR_RESET8;
            high_pin_out    <= '0;
            high_pin_oe_n   <= `DIR_RESET8;
            strobe_pin_out  <= '0;
            strobe_pin_oe_n <= `DIR_RESET4;
        end else begin
            low_pin_out     <= low_nxt.out;
            low_pin_oe_n    <= low_nxt.oe_n;
            high_pin_out    <= high_nxt.out;
            high_pin_oe_n   <= high_nxt.oe_n;
            strobe_pin_out  <= strobe_out_nxt;
            strobe_pin_oe_n <= strobe_oe_nxt;
        end
    end

    // bus data inward and capture pin toward the capture unit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            muxed_address_data_bus <= '0;
            fourth_capture_input   <= 1'b0;
        end else begin
            muxed_address_data_bus <= pins_r[15:0]; // R3 R4
            fourth_capture_input   <= pins_r[16 + `BIT_CAP]; // R9
        end
    end

    // checks
    property p_dir_reset;
        @(posedge clk) $rose(rst_n) |-> low_dir_r == `DIR_RESET8 && strobe_dir_r == `DIR_RESET4;
    endproperty
    a_dir_reset: assert property (p_dir_reset) else $error("dir not reset"); // R12
    property p_io_drive;
        @(posedge clk) disable iff (!rst_n)
        !bus_mode |=> low_pin_oe_n == $past(low_dir_r) && low_pin_out == $past(low_lat_r);
    endproperty
    a_io_drive: assert property (p_io_drive) else $error("io drive wrong"); // R1
    property p_bus_low;
        @(posedge clk) disable iff (!rst_n)
        bus_mode |=> low_pin_out == $past(bus_req.ad_out[7:0]);
    endproperty
    a_bus_low: assert property (p_bus_low) else $error("low bus byte wrong"); // R3
    property p_bus_high;
        @(posedge clk) disable iff (!rst_n)
        bus_mode |=> high_pin_out == $past(bus_req.ad_out[15:8]);
    endproperty
    a_bus_high: assert property (p_bus_high) else $error("high bus byte wrong"); // R4
    property p_strobes;
        @(posedge clk) disable iff (!rst_n)
        bus_mode |=> strobe_pin_oe_n[2:0] == 3'h0
            && strobe_pin_out[`BIT_OE] == $past(bus_req.oe_n)
            && strobe_pin_out[`BIT_WR] == $past(bus_req.wr_n);
    endproperty
    a_strobes: assert property (p_strobes) else $error("strobe drive wrong"); // R5
    property p_cap_pin;
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=> strobe_pin_oe_n[`BIT_CAP] == $past(strobe_dir_r[`BIT_CAP]);
    endproperty
    a_cap_pin: assert property (p_cap_pin) else $error("fourth pin taken"); // R8
    property p_upper_zero;
        @(posedge clk) disable iff (!rst_n)
        reg_rd && sel_ok && reg_addr == `OFS_STROBE_DATA |=> reg_rdata[7:4] == 4'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero"); // R11
    property p_read_pins;
        @(posedge clk) disable iff (!rst_n)
        reg_rd && sel_ok && reg_addr == `OFS_LOW_DATA |=> reg_rdata == $past(pins_r[7:0]);
    endproperty
    a_read_pins: assert property (p_read_pins) else $error("read not pins"); // R2
    property p_bank;
        @(posedge clk) disable iff (!rst_n)
        reg_wr && !sel_ok |=> $stable(low_dir_r) && $stable(high_dir_r);
    endproperty
    a_bank: assert property (p_bank) else $error("wrong bank decoded"); // R14
    c_bus: cover property (@(posedge clk) bus_mode && bus_req.ad_drive);
    c_out: cover property (@(posedge clk) !bus_mode && low_pin_oe_n != 8'hff);
    c_rd:  cover property (@(posedge clk) reg_rd && sel_ok && reg_addr == `OFS_HIGH_DATA);
endmodule

// file: test/pin_partner.sv
// Purpose: far-side pin model for one port
// Assumes: an outside driver holds every pin that the port leaves as input
// Notes:   a pin the port drives shows the port's value
`timescale 1ns/1ns
module pin_partner #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] out,
    input  wire logic [W-1:0] oe_n,
    input  wire logic [W-1:0] ext,
    output logic      [W-1:0] pin
);
    // wire level: port drive where enabled, outside driver elsewhere
    assign pin = (out & ~oe_n) | (ext & oe_n);
endmodule

// file: test/bus_shared_io_ports_tb.sv
// Purpose: self-checking bench for the bus-shared ports
// Assumes: 25 MHz core clock, bank number driven by the bench
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/1ns
`include "bus_io_params.svh"
module bus_shared_io_ports_tb;
    import bus_io_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        por_n = 1'b0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        fci;
    mem_mode_t   mem_mode = mode_microcontroller;
    logic [3:0]  bank_select = 4'h1;
    logic [3:0]  s_in, s_out, s_oe;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic [7:0]  rdata, l_in, l_out, l_oe, h_in, h_out, h_oe, v;
    logic [7:0]  l_ext = 8'h00;
    logic [15:0] mux;
    logic        bm;
    sysbus_req_t bus_req = '0;
    int          fail_count = 0;
    int          compares = 0;
    int          cyc = 0;

    bus_shared_io_ports bus_shared_io_ports_inst (
        .clk(clk), .rst_n(rst_n), .por_n(por_n), .mem_mode(mem_mode),
        .bank_select(bank_select), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(rdata), .bus_req(bus_req),
        .muxed_address_data_bus(mux), .fourth_capture_input(fci),
        .low_pin_in(l_in), .low_pin_out(l_out), .low_pin_oe_n(l_oe),
        .high_pin_in(h_in), .high_pin_out(h_out), .high_pin_oe_n(h_oe),
        .strobe_pin_in(s_in), .strobe_pin_out(s_out), .strobe_pin_oe_n(s_oe));
    pin_partner #(.W(8)) low_inst (.out(l_out), .oe_n(l_oe), .ext(l_ext), .pin(l_in));
    pin_partner #(.W(8)) high_inst (.out(h_out), .oe_n(h_oe), .ext(8'h00), .pin(h_in));
    pin_partner #(.W(4)) strobe_inst (.out(s_out), .oe_n(s_oe), .ext(4'h0), .pin(s_in));

    // clock and hang guard
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            give_verdict();
        end
    end

    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // register write, then one idle edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        wait_n(1);
        reg_wr = 1'b0;
        wait_n(1);
    endtask
    // register read, data taken after one idle edge that follows the read edge
    task automatic rd(input logic [7:0] a);
        reg_addr = a;
        reg_rd = 1'b1;
        wait_n(1);
        reg_rd = 1'b0;
        wait_n(1);
        v = rdata;
    endtask
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // main sequence
    initial begin
        wait_n(8);
        rst_n = 1'b1;
        por_n = 1'b1;
        rd(`OFS_LOW_DIR);
        chk("low dir", v, 8'hff);
        rd(`OFS_HIGH_DIR);
        chk("high dir", v, 8'hff);
        rd(`OFS_STROBE_DIR);
        chk("strobe dir", v, 8'h0f);
        chk("low oe", l_oe, 8'hff);
        chk("strobe oe", s_oe, 4'hf);
        wr(`OFS_STROBE_DIR, 8'hf3);
        rd(`OFS_STROBE_DIR);
        chk("strobe dir upper", v, 8'h03);
        $display("test reset done");
        wr(`OFS_LOW_DATA, 8'h00);
        wr(`OFS_LOW_DATA, 8'ha5);
        wr(`OFS_LOW_DIR, 8'h0f);
        l_ext = 8'h3c;
        wait_n(6);
        chk("low oe", l_oe, 8'h0f);
        chk("low out", l_out & 8'hf0, 8'ha0);
        rd(`OFS_LOW_DATA);
        chk("low pins", v, 8'hac);
        chk("capture low", fci, 1'b0);
        bank_select = 4'h0;
        wr(`OFS_LOW_DATA, 8'hff);
        bank_select = 4'h1;
        wait_n(2);
        chk("bank", l_out & 8'hf0, 8'ha0);
        rd(8'h16);
        chk("unmapped", v, 8'h00);
        wr(`OFS_STROBE_DATA, 8'hfa);
        wr(`OFS_STROBE_DIR, 8'h00);
        // pins need the drive edge plus the input filter before they read back
        wait_n(6);
        rd(`OFS_STROBE_DATA);
        chk("strobe pins", v, 8'h0a);
        $display("test port io done");
        rst_n = 1'b0;
        wait_n(2);
        rst_n = 1'b1;
        rd(`OFS_LOW_DIR);
        chk("dir after reset", v, 8'hff);
        wr(`OFS_LOW_DIR, 8'h00);
        // strobe bits 2..0 stay inputs so bus override of direction shows
        wr(`OFS_STROBE_DIR, 8'h07);
        wait_n(2);
        chk("strobe oe io", s_oe, 4'h7);
        chk("latch kept", l_out, 8'ha5);
        $display("test warm reset done");
        bus_req = '{ad_out: 16'h1234, ad_drive: 1'b1, ale: 1'b1, oe_n: 1'b0, wr_n: 1'b1};
        for (int m = 0; m < 4; m++) begin
            mem_mode = mem_mode_t'(m);
            bm = (m >= 2);
            wait_n(6);
            chk("low out", l_out, bm ? 8'h34 : 8'ha5);
            chk("high oe", h_oe, bm ? 8'h00 : 8'hff);
            chk("high out", h_out, bm ? 8'h12 : 8'h00);
            chk("strobe oe", s_oe, bm ? 4'h0 : 4'h7);
            chk("strobe out", s_out, bm ? 4'hd : 4'ha);
            chk("bus pins", mux, bm ? 16'h1234 : 16'h00a5);
            chk("capture", fci, 1'b1);
        end
        $display("test bus modes done");
        give_verdict();
    end
endmodule
